// file: rtl/dnsc_params.svh
`ifndef DNSC_PARAMS_SVH
`define DNSC_PARAMS_SVH
// ==========================================================
// Register map, field positions and reset values
// Register indices; each register is one word at four times its index
`define DNSC_SYNC_CTRL_IDX    12'h300
`define DNSC_DC0_CTRL_IDX     12'h310
`define DNSC_XFER_IDX         12'h00f
// Byte addresses of the indexed registers
`define DNSC_SYNC_CTRL_ADDR   12'hc00
`define DNSC_DC0_CTRL_ADDR    12'hc40
`define DNSC_XFER_ADDR        12'h03c
// Oscillator word registers, byte addresses of our own choosing
`define DNSC_TUNE_LO_ADDR     12'h320
`define DNSC_TUNE_HI_ADDR     12'h324
`define DNSC_PHASE_ADDR       12'h328
`define DNSC_MOD_A_LO_ADDR    12'h32c
`define DNSC_MOD_A_HI_ADDR    12'h330
`define DNSC_MOD_B_LO_ADDR    12'h334
`define DNSC_MOD_B_HI_ADDR    12'h338
`define DNSC_BIT_UPD_MODE     7
`define DNSC_BIT_SOFT_RST     4
`define DNSC_BIT_NEXT_SYNC    1
`define DNSC_BIT_SYNC_EN      0
`define DNSC_BIT_GAIN         6
`define DNSC_BIT_XFER         0
`define DNSC_SYNC_CTRL_MASK   8'h93
`define DNSC_DC0_CTRL_MASK    8'hff
`define DNSC_RESET_BYTE       8'h00
`endif

// file: rtl/dnsc_pkg.sv
package dnsc_pkg;
  // ==========================================================
  // Oscillator word bundle: tuning, phase and two moduli
  typedef struct packed {
    logic [47:0] freq_tuning_word;
    logic [15:0] phase_offset_word;
    logic [47:0] modulus_a_word;
    logic [47:0] modulus_b_word;
  } dnsc_words_t;
  // AHB data-phase capture
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } dnsc_dphase_t;
endpackage

// file: rtl/dnsc_ctrl.sv
`timescale 1ns/1ns
`include "dnsc_params.svh"

// ==========================================================
// Address map, decoded on the low twelve address bits
// Sync control, downconverter zero control and the transfer
// strobe each sit at four times their register index.
// The transfer strobe is self-clearing and always reads zero.
// Each 48-bit oscillator word is split into a low word and
// a high word; the high word keeps only its low 16 bits.
// Unmapped addresses read zero and ignore writes.
// Upper address bits are not decoded, so the map repeats
// every four kilobytes; keep the select narrow upstream.
// In synchronous update mode the transfer strobe applies
// the staged words as they stood before the strobe cycle.
module dnsc_ctrl
  import dnsc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave side
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Reference input and downconverter zero samples
  input  wire logic        sysref_pin,
  input  wire logic        sysref_input_en,
  input  wire logic [15:0] sample_in,
  output logic      [15:0] sample_out,
  // Oscillator controls
  output dnsc_words_t      osc_words,
  output logic             osc_align,
  output logic             downconverter_reset
);

  // ==========================================================
  // Bus state
  dnsc_dphase_t dph;            // Captured address phase
  dnsc_dphase_t next_dph;
  logic [7:0]   sync_ctrl;      // Update mode, soft reset, sync
  logic [7:0]   next_sync_ctrl;
  logic [7:0]   dc0_ctrl;       // Gain and spare bits
  logic [7:0]   next_dc0_ctrl;
  dnsc_words_t  staged;         // Words as written by software
  dnsc_words_t  next_staged;
  dnsc_words_t  next_osc_words;
  logic [31:0]  next_hrdata;
  logic         wr;             // Data-phase write strobe
  logic [2:0]   sref_sync;      // Two-flop synchroniser plus history
  logic         sref_edge;      // Rising SYSREF edge, clock domain
  logic         align_ok;       // Edge accepted for alignment
  logic [15:0]  next_sample;

  // Decode of a captured address against a register address
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // ==========================================================
  // Bus response: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr        = dph.valid && dph.write;

  // ==========================================================
  // SYSREF synchroniser and edge detect
  // Pin passes two flops; the third keeps the previous level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sref_sync <= 3'h0;
    end else begin
      sref_sync <= {sref_sync[1:0], sysref_pin};
    end
  end
  // Only the second and third stages feed the edge detector
  assign sref_edge = sref_sync[1] && !sref_sync[2];
  // Edge used only when both enables stand and not in soft reset
  assign align_ok  = sref_edge && sync_ctrl[`DNSC_BIT_SYNC_EN] &&
                     sysref_input_en &&
                     !sync_ctrl[`DNSC_BIT_SOFT_RST];

  // ==========================================================
  // Next-value logic for registers and oscillator words
  always_comb begin
    next_dph       = dph;
    next_sync_ctrl = sync_ctrl;
    next_dc0_ctrl  = dc0_ctrl;
    next_staged    = staged;
    next_osc_words = osc_words;
    next_hrdata    = 32'h0;
    // Capture address phase
    // Only a selected NONSEQ or SEQ transfer opens a data phase
    if (hready) begin
      next_dph.valid = hsel && htrans[1];
      next_dph.write = hwrite;
      next_dph.addr  = haddr[11:0];
    end
    // Register writes
    if (wr) begin
      if (hit(dph.addr, `DNSC_SYNC_CTRL_ADDR)) begin
        next_sync_ctrl = hwdata[7:0] & `DNSC_SYNC_CTRL_MASK;
      end
      if (hit(dph.addr, `DNSC_DC0_CTRL_ADDR)) begin
        next_dc0_ctrl = hwdata[7:0] & `DNSC_DC0_CTRL_MASK;
      end
      // Oscillator words land in the staging copy first
      if (hit(dph.addr, `DNSC_TUNE_LO_ADDR)) begin
        next_staged.freq_tuning_word[31:0] = hwdata;
      end
      if (hit(dph.addr, `DNSC_TUNE_HI_ADDR)) begin
        next_staged.freq_tuning_word[47:32] = hwdata[15:0];
      end
      if (hit(dph.addr, `DNSC_PHASE_ADDR)) begin
        next_staged.phase_offset_word = hwdata[15:0];
      end
      if (hit(dph.addr, `DNSC_MOD_A_LO_ADDR)) begin
        next_staged.modulus_a_word[31:0] = hwdata;
      end
      if (hit(dph.addr, `DNSC_MOD_A_HI_ADDR)) begin
        next_staged.modulus_a_word[47:32] = hwdata[15:0];
      end
      if (hit(dph.addr, `DNSC_MOD_B_LO_ADDR)) begin
        next_staged.modulus_b_word[31:0] = hwdata;
      end
      if (hit(dph.addr, `DNSC_MOD_B_HI_ADDR)) begin
        next_staged.modulus_b_word[47:32] = hwdata[15:0];
      end
    end
    // Immediate mode tracks writes; synchronous mode waits
    if (!sync_ctrl[`DNSC_BIT_UPD_MODE]) begin
      next_osc_words = next_staged;
    end else if (wr && hit(dph.addr, `DNSC_XFER_ADDR) &&
                 hwdata[`DNSC_BIT_XFER]) begin
      next_osc_words = staged;
    end
    // One-shot alignment clears enable; hardware clear wins
    // A software write of the enable in that cycle is overridden
    if (align_ok && sync_ctrl[`DNSC_BIT_NEXT_SYNC]) begin
      next_sync_ctrl[`DNSC_BIT_SYNC_EN] = 1'b0;
    end
    // Read data for the next data phase
    // Decoded in the address phase so it stands for the whole
    // data phase; zero in every other cycle
    if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[11:0])
        `DNSC_SYNC_CTRL_ADDR: next_hrdata = {24'h0, next_sync_ctrl};
        `DNSC_DC0_CTRL_ADDR:  next_hrdata = {24'h0, next_dc0_ctrl};
        `DNSC_TUNE_LO_ADDR:
          next_hrdata = next_staged.freq_tuning_word[31:0];
        `DNSC_TUNE_HI_ADDR:
          next_hrdata = {16'h0, next_staged.freq_tuning_word[47:32]};
        `DNSC_PHASE_ADDR:
          next_hrdata = {16'h0, next_staged.phase_offset_word};
        `DNSC_MOD_A_LO_ADDR:
          next_hrdata = next_staged.modulus_a_word[31:0];
        `DNSC_MOD_A_HI_ADDR:
          next_hrdata = {16'h0, next_staged.modulus_a_word[47:32]};
        `DNSC_MOD_B_LO_ADDR:
          next_hrdata = next_staged.modulus_b_word[31:0];
        `DNSC_MOD_B_HI_ADDR:
          next_hrdata = {16'h0, next_staged.modulus_b_word[47:32]};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  // Sample path: unity or doubled gain
  always_comb begin
    if (dc0_ctrl[`DNSC_BIT_GAIN]) begin
      next_sample = {sample_in[14:0], 1'b0};
    end else begin
      next_sample = sample_in;
    end
    // Soft reset zeroes the output so the filters restart clean
    if (sync_ctrl[`DNSC_BIT_SOFT_RST]) begin
      next_sample = 16'h0;
    end
  end

  // ==========================================================
  // Register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph                 <= '0;
      sync_ctrl           <= `DNSC_RESET_BYTE;
      dc0_ctrl            <= `DNSC_RESET_BYTE;
      staged              <= '0;
      osc_words           <= '0;
      hrdata              <= 32'h0;
      sample_out          <= 16'h0;
      osc_align           <= 1'b0;
      downconverter_reset <= 1'b0;
    end else begin
      dph                 <= next_dph;
      sync_ctrl           <= next_sync_ctrl;
      dc0_ctrl            <= next_dc0_ctrl;
      staged              <= next_staged;
      osc_words           <= next_osc_words;
      hrdata              <= next_hrdata;
      sample_out          <= next_sample;
      // Continuous mode realigns on every accepted edge
      osc_align           <= align_ok;
      // Reset output follows the bit from the write edge on
      downconverter_reset <= next_sync_ctrl[`DNSC_BIT_SOFT_RST];
    end
  end

endmodule // dnsc_ctrl

// file: sim/dnsc_sysref_src.sv
`timescale 1ns/1ns
// ==========================================================
// Reference source: one edge per request, 3 ns after the hclk edge that raises go
module dnsc_sysref_src (
  input wire logic go,
  output logic     sysref_pin
);
  // Idle low between edges
  initial sysref_pin = 1'b0;
  // Edges spaced on whole oscillator periods
  always @(posedge go) begin
    #3 sysref_pin = 1'b1;
    #24 sysref_pin = 1'b0;
  end
endmodule // dnsc_sysref_src

// file: sim/dnsc_ctrl_props.sv
`timescale 1ns/1ns
`include "dnsc_params.svh"
// ==========================================================
// Port checks of the oscillator control block
module dnsc_ctrl_props
  import dnsc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sysref_input_en,
  input wire dnsc_words_t osc_words,
  input wire logic        osc_align,
  input wire logic        downconverter_reset
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        rd_dp; // Read data phase
  logic        wr_dp; // Write data phase
  logic [11:0] dp_a;  // Data phase address
  // Track the data phase of each accepted transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
      wr_dp <= 1'b0;
      dp_a  <= 12'h000;
    end else begin
      rd_dp <= hsel && htrans[1] && hready && !hwrite;
      wr_dp <= hsel && htrans[1] && hready && hwrite;
      dp_a  <= haddr[11:0];
    end
  end
  sequence s_rd(a);
    rd_dp && dp_a == a;
  endsequence
  AST_RDY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  AST_ALIGN_PULSE: assert property (osc_align |=> !osc_align)
    else $error("align longer than one cycle");
  AST_NO_SYSREF: assert property (
    !sysref_input_en [*5] |-> !osc_align) else $error("align with input off");
  AST_RST_ALIGN: assert property (
    downconverter_reset && $past(downconverter_reset) |-> !osc_align)
    else $error("align in soft reset");
  AST_HRDATA_IDLE: assert property (!rd_dp |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  AST_RESERVED: assert property (s_rd(`DNSC_SYNC_CTRL_ADDR) |->
    hrdata[31:8] == 24'h0 && hrdata[6:5] == 2'h0 && hrdata[3:2] == 2'h0)
    else $error("reserved bits nonzero");
  AST_XFER_READ: assert property (s_rd(`DNSC_XFER_ADDR) |->
    hrdata == 32'h0)
    else $error("transfer reg reads nonzero");
  AST_WORDS_STABLE: assert property (
    !$past(wr_dp) && !$past(wr_dp, 2) |-> $stable(osc_words))
    else $error("words changed without write");
endmodule // dnsc_ctrl_props
bind dnsc_ctrl dnsc_ctrl_props props_u (
  .hclk               (hclk),
  .hresetn            (hresetn),
  .hsel               (hsel),
  .haddr              (haddr),
  .htrans             (htrans),
  .hwrite             (hwrite),
  .hready             (hready),
  .hrdata             (hrdata),
  .hreadyout          (hreadyout),
  .hresp              (hresp),
  .sysref_input_en    (sysref_input_en),
  .osc_words          (osc_words),
  .osc_align          (osc_align),
  .downconverter_reset(downconverter_reset)
);

// file: sim/dnsc_ctrl_tb.sv
`timescale 1ns/1ns
`include "dnsc_params.svh"
// ==========================================================
// Bench for the oscillator sync control block
module dnsc_ctrl_tb;
  import dnsc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] sample_in = 16'h1234, sample_out;
  logic sysref_pin, sysref_input_en = 1, hready, hreadyout, hresp;
  logic osc_align, downconverter_reset;
  dnsc_words_t osc_words;
  int err_total = 0, compares = 0, aligns = 0;
  assign hready = hreadyout;
  dnsc_ctrl dut_u (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (hsize),
    .hwdata             (hwdata),
    .hready             (hready),
    .hrdata             (hrdata),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .sysref_pin         (sysref_pin),
    .sysref_input_en    (sysref_input_en),
    .sample_in          (sample_in),
    .sample_out         (sample_out),
    .osc_words          (osc_words),
    .osc_align          (osc_align),
    .downconverter_reset(downconverter_reset)
  );
  dnsc_sysref_src src_u (.go(go), .sysref_pin(sysref_pin));
  always #4 hclk = ~hclk;
  // Count alignment pulses
  always @(posedge hclk) if (osc_align === 1'b1) aligns++;
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Bounded wait for hready
  task automatic hold();
    int n = 0;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      err_total++;
      conclude();
    end
  endtask
  // One single AHB transfer, read data left in q
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    q = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e, "read");
  endtask
  task automatic fire();
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (10) @(posedge hclk);
  endtask
  task automatic t_regs();
    rd(`DNSC_SYNC_CTRL_ADDR, 32'h0);
    rd(`DNSC_DC0_CTRL_ADDR, 32'h0);
    rd(12'h3f0, 32'h0);
    chk(sample_out, 16'h1234, "unity");
    bus(1'b1, `DNSC_DC0_CTRL_ADDR, 32'h40);
    repeat (2) @(posedge hclk);
    chk(sample_out, 16'h2468, "gain");
    $display("regs done");
  endtask
  task automatic t_update();
    bus(1'b1, `DNSC_TUNE_LO_ADDR, 32'h11223344);
    @(posedge hclk);
    chk(osc_words.freq_tuning_word, 48'h11223344, "tuning");
    bus(1'b1, `DNSC_TUNE_HI_ADDR, 32'hffffaabb);
    bus(1'b1, `DNSC_MOD_A_LO_ADDR, 32'h01020304);
    bus(1'b1, `DNSC_MOD_A_HI_ADDR, 32'h00000506);
    bus(1'b1, `DNSC_MOD_B_LO_ADDR, 32'h0708090a);
    bus(1'b1, `DNSC_MOD_B_HI_ADDR, 32'h00000b0c);
    @(posedge hclk);
    chk(osc_words.freq_tuning_word, 48'haabb11223344, "tuning hi");
    chk(osc_words.modulus_a_word, 48'h050601020304, "modulus a");
    chk(osc_words.modulus_b_word, 48'h0b0c0708090a, "modulus b");
    rd(`DNSC_TUNE_HI_ADDR, 32'h0000aabb);
    bus(1'b1, `DNSC_SYNC_CTRL_ADDR, 32'h80);
    bus(1'b1, `DNSC_PHASE_ADDR, 32'hbeef);
    repeat (2) @(posedge hclk);
    chk(osc_words.phase_offset_word, 16'h0, "held");
    bus(1'b1, `DNSC_XFER_ADDR, 32'h1);
    repeat (2) @(posedge hclk);
    chk(osc_words.phase_offset_word, 16'hbeef, "xfer");
    rd(`DNSC_XFER_ADDR, 32'h0);
    bus(1'b1, `DNSC_SYNC_CTRL_ADDR, 32'h11);
    repeat (2) @(posedge hclk);
    chk({downconverter_reset, sample_out}, 17'h10000, "srst");
    fire();
    chk(aligns, 0, "align in soft reset");
    $display("update done");
  endtask
  task automatic t_sync();
    bus(1'b1, `DNSC_SYNC_CTRL_ADDR, 32'h3);
    fire();
    chk(aligns, 1, "one shot");
    rd(`DNSC_SYNC_CTRL_ADDR, 32'h2);
    fire();
    chk(aligns, 1, "later edge");
    bus(1'b1, `DNSC_SYNC_CTRL_ADDR, 32'h1);
    fire();
    fire();
    chk(aligns, 3, "continuous");
    rd(`DNSC_SYNC_CTRL_ADDR, 32'h1);
    sysref_input_en <= 1'b0;
    fire();
    chk(aligns, 3, "input off");
    $display("sync done");
  endtask
  // Second reset in mid-run returns every field to zero
  task automatic t_reset();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`DNSC_SYNC_CTRL_ADDR, 32'h0);
    rd(`DNSC_DC0_CTRL_ADDR, 32'h0);
    chk(osc_words.phase_offset_word, 16'h0, "words reset");
    chk(downconverter_reset, 1'b0, "soft reset off");
    $display("reset done");
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_update();
    t_sync();
    t_reset();
    conclude();
  end
endmodule // dnsc_ctrl_tb
